// ### gst_far_side.sv
// External count clock source that feeds the timer pin.
`timescale 1ns/1ps
`default_nettype none
module gst_far_side #(
  parameter int HALF = 5
) (
  // Clock and control
  input  wire logic aclk,
  input  wire logic run,
  // Count clock
  output wire logic ext_clk
);
  // ====================
  // Clock generator
  int   cnt_q = 0;
  logic tgl_q = 1'h0;
  assign ext_clk = tgl_q;
  // Rising edges every 2*HALF cycles; idles low between bursts.
  always_ff @(posedge aclk)
  begin
    if (!run || cnt_q == HALF - 1)
      cnt_q <= 0;
    else
      cnt_q <= cnt_q + 1;
    if (!run)
      tgl_q <= 1'h0;
    else if (cnt_q == HALF - 1)
      tgl_q <= ~tgl_q;
  end
endmodule : gst_far_side
`default_nettype wire

// ### gst_pkg.sv
// Package with register map, field layout and constants of the gated sixteen-bit timer.
`default_nettype none
package gst_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] GST_OFF_CTRL  = 8'h00;
  localparam logic [7:0] GST_OFF_COUNT = 8'h04;
  localparam logic [7:0] GST_OFF_IRQ   = 8'h08;
  localparam logic [7:0] GST_OFF_PORT  = 8'h0c;
  localparam logic [7:0] GST_OFF_CAPT  = 8'h10;
  localparam logic [7:0] GST_OFF_CMP   = 8'h14;
  // ==========================================================================
  // Control register fields
  localparam int GST_B_TIMER_ON = 0;
  localparam int GST_B_CLK_SRC  = 1;
  localparam int GST_B_SYNC_DIS = 2;
  localparam int GST_B_OSC_EN   = 3;
  localparam int GST_B_PS_LO    = 4;
  localparam int GST_B_GATE_EN  = 6;
  localparam int GST_B_GATE_INV = 7;
  localparam int GST_B_GATE_SRC = 8;
  localparam int GST_B_CMP_SYNC = 9;
  // Interrupt register fields
  localparam int GST_B_OVF_FLAG = 0;
  localparam int GST_B_OVF_IE   = 1;
  localparam int GST_B_PERI_IE  = 2;
  localparam int GST_B_GLOB_IE  = 3;
  localparam int GST_B_ASLEEP   = 4;
  // ==========================================================================
  // Reset values and responses
  localparam logic [9:0]  GST_CTRL_RST = 10'h000;
  localparam logic [15:0] GST_COUNT_RST = 16'h0000;
  localparam logic [15:0] GST_COUNT_MAX = 16'hffff;
  localparam logic [1:0]  GST_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  GST_RESP_SLVERR = 2'b10;
  localparam logic [15:0] GST_VECTOR = 16'h0004;
  // ==========================================================================
  // Carrier of the decoded control word
  typedef struct packed {
    logic       cmp_sync;
    logic       gate_src;
    logic       gate_inv;
    logic       gate_en;
    logic [1:0] prescale_select;
    logic       crystal_osc_enable;
    logic       sync_disable;
    logic       clock_source_select;
    logic       timer_on;
  } gst_ctrl_s;
endpackage : gst_pkg
`default_nettype wire

// ### gst_timer.sv
// Gated sixteen-bit timer with prescaler, gate, overflow flag and AXI4-Lite registers.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gst_timer
  import gst_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pins and neighbours
  input  wire logic        external_count_input,
  input  wire logic        gate_input_pin,
  input  wire logic        comparator_two_out,
  input  wire logic        capture_event,
  input  wire logic        special_event,
  input  wire logic        sleep_mode,
  // Outputs
  output var  logic        crystal_osc_run,
  output var  logic        portc_dir_force,
  output var  logic [15:0] count_value,
  output var  logic        compare_match,
  output var  logic        count_tick,
  output var  logic        comparator_sync_out,
  output var  logic        irq_request,
  output var  logic        wake_request,
  output var  logic        vector_request
);

  // ==========================================================================
  // Pin synchronisers
  logic [2:0] ext_meta_q, ext_sync_q;
  logic       ext_prev_q;
  logic       gate_pin_q, gate_pin_s_q, cmp_meta_q, cmp_s_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_meta_q   <= 3'h0;
      ext_sync_q   <= 3'h0;
      gate_pin_q   <= 1'b0;
      gate_pin_s_q <= 1'b0;
      cmp_meta_q   <= 1'b0;
      cmp_s_q      <= 1'b0;
    end
    else if (clk_en)
    begin
      ext_meta_q   <= {ext_meta_q[1:0], external_count_input};
      ext_sync_q   <= {ext_sync_q[1:0], ext_meta_q[2]};
      gate_pin_q   <= gate_input_pin;
      gate_pin_s_q <= gate_pin_q;
      cmp_meta_q   <= comparator_two_out;
      cmp_s_q      <= cmp_meta_q;
    end
  end

  // ==========================================================================
  // Registers
  gst_ctrl_s  ctrl_q;
  logic [15:0] count_q, count_d, capt_q, cmp_q;
  logic [2:0]  pre_q;
  logic [1:0]  div4_q;
  logic        ovf_q, ovf_ie_q, peri_ie_q, glob_ie_q;
  logic        fall_seen_q, in_prev_q;

  // ==========================================================================
  // Bus slave decode
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  wire         wr_fire   = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire         wr_ctrl   = wr_fire && (aw_addr_q == GST_OFF_CTRL);
  wire         wr_count  = wr_fire && (aw_addr_q == GST_OFF_COUNT);
  wire         wr_irq    = wr_fire && (aw_addr_q == GST_OFF_IRQ);
  wire         wr_cmp    = wr_fire && (aw_addr_q == GST_OFF_CMP);
  wire         wr_known  = wr_ctrl || wr_count || wr_irq || wr_cmp;
  wire         wr_lo     = wr_count && w_strb_q[0];
  wire         wr_hi     = wr_count && w_strb_q[1];
  wire         wr_cnt_any = wr_lo || wr_hi;

  // ==========================================================================
  // Clock selection, prescaler and gate
  wire ext_sel   = ctrl_q.clock_source_select;
  // Asynchronous path takes ext_meta_q[2], three flops in; synchronous path takes ext_sync_q[2], six flops in.
  wire ext_lvl   = ctrl_q.sync_disable ? ext_meta_q[2] : ext_sync_q[2];
  wire ext_rise  = ext_lvl && !in_prev_q && fall_seen_q;
  wire int_tick  = (div4_q == 2'h3);
  wire src_tick  = ext_sel ? ext_rise : int_tick;
  wire [2:0] pre_mask = (3'h1 << ctrl_q.prescale_select) - 3'h1;
  wire pre_done  = (pre_q & pre_mask) == pre_mask;
  wire gate_raw  = ctrl_q.gate_src ? cmp_s_q : gate_pin_s_q;
  // Gate is active low unless inverted; inverted gate counts while the gate is high.
  wire gate_open = !ctrl_q.gate_en || (gate_raw == ctrl_q.gate_inv);
  wire sleep_ok  = !sleep_mode || (ext_sel && ctrl_q.sync_disable);
  wire run       = ctrl_q.timer_on && gate_open && sleep_ok;
  wire inc       = run && src_tick && pre_done;
  wire wrap      = inc && (count_q == GST_COUNT_MAX);
  wire sev_clear = special_event && !wr_cnt_any;

  always_comb
  begin
    count_d = count_q;
    if (wr_cnt_any)
    begin
      // A byte write replaces that byte of the live count.
      if (wr_lo)
        count_d[7:0] = w_data_q[7:0];
      if (wr_hi)
        count_d[15:8] = w_data_q[15:8];
    end
    else if (sev_clear)
      count_d = GST_COUNT_RST;
    else if (inc)
      count_d = count_q + 16'h0001;
  end

  // ==========================================================================
  // Counting state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q     <= GST_COUNT_RST;
      pre_q       <= 3'h0;
      div4_q      <= 2'h0;
      in_prev_q   <= 1'b0;
      fall_seen_q <= 1'b0;
      capt_q      <= 16'h0000;
    end
    else if (clk_en)
    begin
      count_q   <= count_d;
      div4_q    <= div4_q + 2'h1;
      in_prev_q <= ext_lvl;
      if (wr_cnt_any)
        pre_q <= 3'h0;
      else if (run && src_tick)
        pre_q <= pre_done ? 3'h0 : pre_q + 3'h1;
      // Arm only after the input is seen low while the timer is on.
      if (wr_cnt_any || !ctrl_q.timer_on)
        fall_seen_q <= fall_seen_q && !wr_cnt_any && !ext_lvl;
      else if (!ext_lvl)
        fall_seen_q <= 1'b1;
      if (capture_event)
        capt_q <= count_q;
    end
  end

  // ==========================================================================
  // Control and interrupt registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q    <= GST_CTRL_RST;
      cmp_q     <= 16'hffff;
      ovf_q     <= 1'b0;
      ovf_ie_q  <= 1'b0;
      peri_ie_q <= 1'b0;
      glob_ie_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_ctrl && w_strb_q[0])
        ctrl_q[7:0] <= w_data_q[7:0];
      if (wr_ctrl && w_strb_q[1])
        ctrl_q[9:8] <= w_data_q[9:8];
      if (wr_cmp && w_strb_q[0])
        cmp_q[7:0] <= w_data_q[7:0];
      if (wr_cmp && w_strb_q[1])
        cmp_q[15:8] <= w_data_q[15:8];
      if (wr_irq && w_strb_q[0])
      begin
        ovf_ie_q  <= w_data_q[GST_B_OVF_IE];
        peri_ie_q <= w_data_q[GST_B_PERI_IE];
        glob_ie_q <= w_data_q[GST_B_GLOB_IE];
      end
      // Overflow sets win over a software clear of the flag.
      if (wrap && !sev_clear && !wr_cnt_any)
        ovf_q <= 1'b1;
      else if (wr_irq && w_strb_q[0] && !w_data_q[GST_B_OVF_FLAG])
        ovf_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Output flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      crystal_osc_run     <= 1'b0;
      portc_dir_force     <= 1'b0;
      count_value         <= GST_COUNT_RST;
      compare_match       <= 1'b0;
      count_tick          <= 1'b0;
      comparator_sync_out <= 1'b0;
      irq_request         <= 1'b0;
      wake_request        <= 1'b0;
      vector_request      <= 1'b0;
    end
    else if (clk_en)
    begin
      crystal_osc_run <= ctrl_q.crystal_osc_enable;
      portc_dir_force <= ctrl_q.crystal_osc_enable;
      count_value     <= count_d;
      compare_match   <= (count_d == cmp_q);
      count_tick      <= inc;
      if (ctrl_q.cmp_sync && inc)
        comparator_sync_out <= cmp_s_q;
      else if (!ctrl_q.cmp_sync)
        comparator_sync_out <= cmp_s_q;
      irq_request    <= ovf_q && ovf_ie_q && peri_ie_q && glob_ie_q;
      wake_request   <= sleep_mode && ovf_q && ovf_ie_q && peri_ie_q
                        && ctrl_q.timer_on && ctrl_q.sync_disable;
      vector_request <= sleep_mode && ovf_q && ovf_ie_q && peri_ie_q
                        && ctrl_q.timer_on && glob_ie_q;
    end
  end

  // ==========================================================================
  // AXI4-Lite handshakes
  wire        ar_fire = s_axi_arvalid && s_axi_arready;
  // Reads of the count return the live count_q as one word.
  wire [31:0] rd_mux =
    (s_axi_araddr == GST_OFF_CTRL)  ? {22'h0, ctrl_q} :
    (s_axi_araddr == GST_OFF_COUNT) ? {16'h0, count_q} :
    (s_axi_araddr == GST_OFF_IRQ)   ? {27'h0, sleep_mode, glob_ie_q, peri_ie_q,
                                       ovf_ie_q, ovf_q} :
    (s_axi_araddr == GST_OFF_PORT)  ? {28'h0, {2{ctrl_q.crystal_osc_enable}}, 2'b00} :
    (s_axi_araddr == GST_OFF_CAPT)  ? {16'h0, capt_q} :
    (s_axi_araddr == GST_OFF_CMP)   ? {16'h0, cmp_q} : 32'h0;
  wire        rd_known = (s_axi_araddr == GST_OFF_CTRL) || (s_axi_araddr == GST_OFF_COUNT)
                      || (s_axi_araddr == GST_OFF_IRQ) || (s_axi_araddr == GST_OFF_PORT)
                      || (s_axi_araddr == GST_OFF_CAPT) || (s_axi_araddr == GST_OFF_CMP);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= GST_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= GST_RESP_OKAY;
    end
    else if (clk_en)
    begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? GST_RESP_OKAY : GST_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (ar_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_known ? GST_RESP_OKAY : GST_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule : gst_timer
`default_nettype wire

// ### gst_timer_asserts.sv
// Concurrent checks on the ports of the gated sixteen-bit timer.
`timescale 1ns/1ps
`default_nettype none
module gst_timer_asserts
  import gst_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  // Bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // Timer
  input wire logic        special_event,
  input wire logic        sleep_mode,
  input wire logic        crystal_osc_run,
  input wire logic        portc_dir_force,
  input wire logic [15:0] count_value,
  input wire logic        count_tick,
  input wire logic        irq_request,
  input wire logic        wake_request,
  input wire logic        vector_request
);
  // ====================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_osc_dir_tie: assert property (crystal_osc_run == portc_dir_force)
    else $error("port force differs from oscillator");
  a_tick_single: assert property (count_tick |=> !count_tick)
    else $error("tick lasted two cycles");
  a_vector_irq: assert property (vector_request |-> irq_request)
    else $error("vector without interrupt");
  a_vector_sleep: assert property (vector_request |-> $past(sleep_mode))
    else $error("vector while awake");
  a_wake_sleep: assert property (wake_request |-> $past(sleep_mode))
    else $error("wake while awake");
  a_special_clear: assert property (special_event && clk_en && !s_axi_awvalid
    && !s_axi_awready && !$past(s_axi_awready) |=> count_value == 16'h0000)
    else $error("special event did not clear");
  a_err_data_zero: assert property (s_axi_rvalid && s_axi_rresp == GST_RESP_SLVERR
    |-> s_axi_rdata == 32'h0)
    else $error("error read with data");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready held");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
endmodule : gst_timer_asserts
bind gst_timer gst_timer_asserts chk_u (.aclk, .aresetn, .clk_en, .s_axi_awvalid,
  .s_axi_awready, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata,
  .special_event, .sleep_mode, .crystal_osc_run, .portc_dir_force, .count_value,
  .count_tick, .irq_request, .wake_request, .vector_request);
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the gated sixteen-bit timer.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import gst_pkg::*;
;
  // ====================
  // Signals
  typedef struct packed {logic [9:0] ctl; logic [2:0] pin; logic [7:0] per;} gst_row_s;
  logic aclk = 1'h0, aresetn = 1'h0, ext_run = 1'h0, external_count_input;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, gate_input_pin = 1'h0;
  logic comparator_two_out = 1'h0, capture_event = 1'h0, special_event = 1'h0;
  logic sleep_mode = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, per;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
  logic s_axi_rvalid, crystal_osc_run, portc_dir_force, compare_match, count_tick;
  logic comparator_sync_out, irq_request, wake_request, vector_request;
  logic [15:0] count_value;
  int fail_count = 0, comparisons = 0;
  gst_row_s rows [15] = '{'{10'h001, 3'h0, 8'h04}, '{10'h011, 3'h0, 8'h08},
    '{10'h021, 3'h0, 8'h10}, '{10'h031, 3'h0, 8'h20}, '{10'h041, 3'h0, 8'h04},
    '{10'h041, 3'h4, 8'h00}, '{10'h0c1, 3'h4, 8'h04}, '{10'h0c1, 3'h0, 8'h00},
    '{10'h1c1, 3'h2, 8'h04}, '{10'h1c1, 3'h4, 8'h00}, '{10'h001, 3'h4, 8'h04},
    '{10'h000, 3'h0, 8'h00}, '{10'h003, 3'h1, 8'h0a}, '{10'h013, 3'h1, 8'h14},
    '{10'h007, 3'h1, 8'h0a}};
  always #4 aclk = ~aclk;
  gst_far_side far_u (.aclk, .run(ext_run), .ext_clk(external_count_input));
  gst_timer dut_u (.aclk, .aresetn, .clk_en(1'h1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_count_input,
    .gate_input_pin, .comparator_two_out, .capture_event, .special_event, .sleep_mode,
    .crystal_osc_run, .portc_dir_force, .count_value, .compare_match, .count_tick,
    .comparator_sync_out, .irq_request, .wake_request, .vector_request);
  // ====================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    aw = 1'h0;
    w = 1'h0;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic tick_gap(output logic [7:0] p);
    int n;
    n = 0;
    p = 8'h00;
    while (!count_tick && n < 90)
    begin
      @(posedge aclk);
      n++;
    end
    n = (n < 90) ? 0 : 99;
    while (n < 90 && (n == 0 || !count_tick))
    begin
      @(posedge aclk);
      n++;
    end
    if (n < 90) p = n[7:0];
  endtask : tick_gap
  task automatic wrap_up();
    if (fail_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic pause(input int n);
    repeat (n) @(posedge aclk);
  endtask : pause
  // ====================
  // Tests
  initial
  begin
    pause(2);
    aresetn <= 1'h1;
    foreach (rows[i])
    begin
      {gate_input_pin, comparator_two_out, ext_run} <= rows[i].pin;
      wr(GST_OFF_CTRL, {22'h0, rows[i].ctl}, 4'hf);
      pause(12);
      tick_gap(per);
      chk(per, rows[i].per);
    end
    aresetn <= 1'h0;
    {gate_input_pin, comparator_two_out, ext_run} <= 3'h0;
    pause(2);
    aresetn <= 1'h1;
    rd(GST_OFF_CTRL);
    chk(rdat, 32'h0);
    rd(GST_OFF_CMP);
    chk(rdat, 32'hffff);
    rd(8'h40);
    chk(rrsp, GST_RESP_SLVERR);
    wr(GST_OFF_COUNT, 32'habcd, 4'h3);
    wr(GST_OFF_COUNT, 32'h12, 4'h1);
    wr(GST_OFF_COUNT, 32'h5600, 4'h2);
    rd(GST_OFF_COUNT);
    chk(rdat, 32'h5612);
    capture_event <= 1'h1;
    pause(1);
    capture_event <= 1'h0;
    rd(GST_OFF_CAPT);
    chk(rdat, 32'h5612);
    wr(GST_OFF_CMP, 32'h5612, 4'h3);
    pause(3);
    chk(compare_match, 1'h1);
    wr(GST_OFF_IRQ, 32'h6, 4'hf);
    wr(GST_OFF_COUNT, 32'hfffe, 4'h3);
    wr(GST_OFF_CTRL, 32'h1, 4'hf);
    pause(20);
    wr(GST_OFF_CTRL, 32'h0, 4'hf);
    rd(GST_OFF_IRQ);
    chk(rdat, 32'h7);
    chk(irq_request, 1'h0);
    wr(GST_OFF_IRQ, 32'hf, 4'hf);
    pause(2);
    chk(irq_request, 1'h1);
    wr(GST_OFF_IRQ, 32'he, 4'hf);
    wr(GST_OFF_CTRL, 32'h1, 4'hf);
    pause(5);
    special_event <= 1'h1;
    pause(1);
    special_event <= 1'h0;
    wr(GST_OFF_CTRL, 32'h0, 4'hf);
    rd(GST_OFF_IRQ);
    chk(rdat, 32'he);
    chk(irq_request, 1'h0);
    wr(GST_OFF_CTRL, 32'h8, 4'hf);
    pause(2);
    chk(crystal_osc_run, 1'h1);
    rd(GST_OFF_PORT);
    chk(rdat & 32'hf, 32'hc);
    comparator_two_out <= 1'h1;
    wr(GST_OFF_CTRL, 32'h209, 4'hf);
    pause(12);
    chk(comparator_sync_out, 1'h1);
    wr(GST_OFF_CTRL, 32'h0, 4'hf);
    sleep_mode <= 1'h1;
    ext_run <= 1'h1;
    wr(GST_OFF_COUNT, 32'hfffe, 4'h3);
    wr(GST_OFF_IRQ, 32'h6, 4'hf);
    wr(GST_OFF_CTRL, 32'h7, 4'hf);
    pause(60);
    chk(wake_request, 1'h1);
    chk(vector_request, 1'h0);
    wr(GST_OFF_IRQ, 32'hf, 4'hf);
    pause(2);
    chk(vector_request, 1'h1);
    wrap_up();
  end
  initial
  begin
    pause(20000);
    fail_count++;
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
